/* File: core/dcms_defs.vh */
/*
 * Register offsets, field positions, reset values and timing counts for
 * the control-mode and conversion-mode selection block of a 2-channel DAC.
 * Assumes it is included by bare name from the design files.
 */
`ifndef DCMS_DEFS_VH
`define DCMS_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DCMS_ADDR_MODE_CLK 5'h00
`define DCMS_ADDR_FILT_DEM 5'h01
`define DCMS_ADDR_MONO_DSD 5'h02
`define DCMS_ADDR_ATT_L 5'h03
`define DCMS_ADDR_ATT_R 5'h04
`define DCMS_ADDR_FILT_POL 5'h05
`define DCMS_ADDR_DSD_MUTE 5'h06
`define DCMS_ADDR_GAIN_SYNC 5'h07
`define DCMS_ADDR_SOUND_Q 5'h08
`define DCMS_ADDR_DSD_FILT 5'h09
`define DCMS_ADDR_MULTICH 5'h0a
`define DCMS_ADDR_DAISY 5'h0b
`define DCMS_ADDR_AUTO_SW 5'h15

// ****************************************************************
// Field positions
// ****************************************************************
`define DCMS_B0_SOFT_RESET 0
`define DCMS_B0_EXT_FILTER 1
`define DCMS_B0_CLK_AUTO 7
`define DCMS_B1_ZERO_DET_EN 7
`define DCMS_B1_SOFT_MUTE 0
`define DCMS_B1_SHORT_DELAY 5
`define DCMS_B2_DSD_MODE 7
`define DCMS_B2_ZERO_POL 4
`define DCMS_B2_MONO 3
`define DCMS_B2_CH_SELECT 1
`define DCMS_B5_INV_L 7
`define DCMS_B5_INV_R 6
`define DCMS_B5_SUPER_SLOW 0
`define DCMS_B6_PORT_SEL 2
`define DCMS_B6_ROUTE 1
`define DCMS_B6_FS_MUTE 0
`define DCMS_B7_SYNC_EN 0
`define DCMS_B15_AUTO_EN 7

// ****************************************************************
// Reset values
// ****************************************************************
`define DCMS_RST_MODE_CLK 8'h00
`define DCMS_RST_FILT_DEM 8'h00
`define DCMS_RST_MONO_DSD 8'h00
`define DCMS_RST_ATT 8'hff
`define DCMS_RST_FILT_POL 8'h00
`define DCMS_RST_DSD_MUTE 8'h00
`define DCMS_RST_GAIN_SYNC 8'h01
`define DCMS_RST_OTHER 8'h00
`define DCMS_ATT_0DB 8'hff
`define DCMS_SQ_PIN 3'h0

// ****************************************************************
// Conversion modes and timing
// ****************************************************************
`define DCMS_MODE_PCM 2'h0
`define DCMS_MODE_EXT_FILTER_MODE_BIT 2'h1
`define DCMS_MODE_DSD 2'h2
`define DCMS_SWITCH_MIN_FSB 2
`define DCMS_SWITCH_MAX_FSB 3

`endif

/* File: core/dcms_mode_decode.v */
/*
 * Conversion-mode decoder: turns control mode, mode bits and the input
 * activity detector into one of PCM, external-filter or DSD.
 * Assumes the detector input is already synchronous to the clock.
 */
`timescale 1ns/1ps
`include "dcms_defs.vh"

module dcms_mode_decode (
  input wire i_pin_ctrl,
  input wire i_auto_en,
  input wire i_dsd_bit,
  input wire i_ext_filter_mode_bit_bit,
  input wire i_dsd_detected,
  output reg [1:0] o_mode
);

  always @* begin
    if (i_pin_ctrl) begin
      o_mode = `DCMS_MODE_PCM;
    end else if (i_auto_en) begin
      if (i_dsd_detected) begin
        o_mode = `DCMS_MODE_DSD;
      end else if (i_ext_filter_mode_bit_bit) begin
        o_mode = `DCMS_MODE_EXT_FILTER_MODE_BIT;
      end else begin
        o_mode = `DCMS_MODE_PCM;
      end
    end else if (i_dsd_bit) begin
      o_mode = `DCMS_MODE_DSD;
    end else if (i_ext_filter_mode_bit_bit) begin
      o_mode = `DCMS_MODE_EXT_FILTER_MODE_BIT;
    end else begin
      o_mode = `DCMS_MODE_PCM;
    end
  end

endmodule // dcms_mode_decode

/* File: core/dcms_switch_timer.v */
/*
 * Switchover timer: counts base-rate sample ticks after a conversion
 * mode change and reports when the internal data path has switched.
 * Assumes i_fsb_tick is a one-cycle pulse once per base sample period.
 */
`timescale 1ns/1ps
`include "dcms_defs.vh"

module dcms_switch_timer #(
  parameter CNT_W = 2
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_start,
  input wire i_fsb_tick,
  output reg o_busy
);

  reg [CNT_W-1:0] cnt_q;

  // ****************************************************************
  // Counting
  // ****************************************************************
  // Three ticks after the change: the first tick may follow at once, so
  // the switch lands between two and three full sample periods.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= {CNT_W{1'b0}};
      o_busy <= 1'b0;
    end else if (i_start) begin
      cnt_q <= {CNT_W{1'b0}};
      o_busy <= 1'b1;
    end else if (o_busy && i_fsb_tick) begin
      if (cnt_q == `DCMS_SWITCH_MAX_FSB - 1) begin
        o_busy <= 1'b0;
      end
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // dcms_switch_timer

/* File: core/dcms_ctrl.v */
/*
 * Control-mode and conversion-mode selection for a 2-channel DAC:
 * register bank, pin/register control arbitration, input port routing
 * and the effective function settings applied to the datapath.
 * Assumes all pins and the register write port are synchronous to i_clk,
 * and that i_resetn follows the power-down pin.
 */
// How it works
// - Select pin low means register control, high means pin control.
// - Pin control ignores registers; register control ignores function pins.
// - Pin control forces PCM conversion.
// - DSD input from port B when port-select is 0, port A when 1.
// - PCM uses bit/frame/data inputs; ext filter uses its four inputs.
// - Without auto switching, mode comes only from DSD and ext-filter bits.
// - DSD bit wins; else ext-filter bit chooses ext filter or PCM.
// - Auto switching picks DSD from input activity, ext bit picks other.
// - Data path switchover completes two to three base samples after change.
// - Octal and hex speed force the super-slow filter.
// - Pin control fixes attenuation at 0 dB and disables zero detection.
// - Pin control de-emphasis only offers the 44.1 kHz curve.
// - Pin control is stereo only, no mono or channel swap.
// - Pin control inverts right channel only; sound quality as code 000.
// - Pin control keeps standby, clock sync enabled and soft reset released.
// - Register control defaults to manual clock setting, PCM only.
// - Attenuation registers default 0 dB, bypassed in DSD volume-bypass.
// - Zero flags high on zero, inverted by polarity bit under register control.
// - DSD full-scale mute defaults off, active only in DSD modes.
`timescale 1ns/1ps
`include "dcms_defs.vh"

module dcms_ctrl #(
  parameter ADDR_W = 5
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_control_mode_select_pin,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  input wire i_pin_clk_auto,
  input wire i_pin_short_delay,
  input wire i_pin_super_slow,
  input wire i_pin_deemph_on,
  input wire i_pin_invert_r,
  input wire i_pin_soft_mute,
  input wire i_high_speed,
  input wire i_dsd_detected,
  input wire i_fsb_tick,
  input wire i_zero_l,
  input wire i_zero_r,
  input wire i_pcm_bit_clock,
  input wire i_pcm_frame_clock,
  input wire i_pcm_serial_data,
  input wire i_ext_filter_bit_clock,
  input wire i_ext_filter_left_data,
  input wire i_ext_filter_right_data,
  input wire i_ext_filter_word_clock,
  input wire i_dsd_port_a_clock,
  input wire i_dsd_port_a_left,
  input wire i_dsd_port_a_right,
  input wire i_dsd_port_b_clock,
  input wire i_dsd_port_b_left,
  input wire i_dsd_port_b_right,
  output reg o_pin_ctrl,
  output reg [1:0] o_mode,
  output reg o_switching,
  output reg o_core_reset,
  output reg o_bit_clock,
  output reg o_frame_clock,
  output reg o_left_data,
  output reg o_right_data,
  output reg o_clk_auto,
  output reg o_short_delay,
  output reg o_super_slow,
  output reg [1:0] o_deemph,
  output reg [7:0] o_atten_l,
  output reg [7:0] o_atten_r,
  output reg o_mono,
  output reg o_ch_select,
  output reg o_invert_l,
  output reg o_invert_r,
  output reg [2:0] o_sound_quality,
  output reg o_soft_mute,
  output reg o_mclk_standby_en,
  output reg o_clock_sync_en,
  output reg o_dsd_fs_mute,
  output reg o_zero_flag_l,
  output reg o_zero_flag_r
);

  localparam DEEMPH_44K1 = 2'h0;
  localparam DEEMPH_OFF = 2'h1;

  // ****************************************************************
  // Register bank
  // ****************************************************************
  reg [7:0] r_mode_clk_q;
  reg [7:0] r_filt_dem_q;
  reg [7:0] r_mono_dsd_q;
  reg [7:0] r_att_l_q;
  reg [7:0] r_att_r_q;
  reg [7:0] r_filt_pol_q;
  reg [7:0] r_dsd_mute_q;
  reg [7:0] r_gain_sync_q;
  reg [7:0] r_sound_q_q;
  reg [7:0] r_dsd_filt_q;
  reg [7:0] r_multich_q;
  reg [7:0] r_daisy_q;
  reg [7:0] r_auto_sw_q;
  reg [1:0] mode_prev_q;
  wire pin_ctrl;
  wire [1:0] mode_d;
  wire busy;
  reg [7:0] rdata_d;

  // The select pin is sampled live; the host holds power-down across a
  // change so the registers below restart from reset values.
  assign pin_ctrl = i_control_mode_select_pin;

  function wr_hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] target;
    begin
      wr_hit = i_wr_en && (addr == target);
    end
  endfunction

  // Writes are refused under pin control, so register state is ignored.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      r_mode_clk_q <= `DCMS_RST_MODE_CLK;
      r_filt_dem_q <= `DCMS_RST_FILT_DEM;
      r_mono_dsd_q <= `DCMS_RST_MONO_DSD;
      r_att_l_q <= `DCMS_RST_ATT;
      r_att_r_q <= `DCMS_RST_ATT;
      r_filt_pol_q <= `DCMS_RST_FILT_POL;
      r_dsd_mute_q <= `DCMS_RST_DSD_MUTE;
      r_gain_sync_q <= `DCMS_RST_GAIN_SYNC;
      r_sound_q_q <= `DCMS_RST_OTHER;
      r_dsd_filt_q <= `DCMS_RST_OTHER;
      r_multich_q <= `DCMS_RST_OTHER;
      r_daisy_q <= `DCMS_RST_OTHER;
      r_auto_sw_q <= `DCMS_RST_OTHER;
    end else if (!pin_ctrl) begin
      if (wr_hit(i_addr, `DCMS_ADDR_MODE_CLK)) r_mode_clk_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_FILT_DEM)) r_filt_dem_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_MONO_DSD)) r_mono_dsd_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_ATT_L)) r_att_l_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_ATT_R)) r_att_r_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_FILT_POL)) r_filt_pol_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_DSD_MUTE)) r_dsd_mute_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_GAIN_SYNC)) r_gain_sync_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_SOUND_Q)) r_sound_q_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_DSD_FILT)) r_dsd_filt_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_MULTICH)) r_multich_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_DAISY)) r_daisy_q <= i_wdata;
      if (wr_hit(i_addr, `DCMS_ADDR_AUTO_SW)) r_auto_sw_q <= i_wdata;
    end
  end

  always @* begin
    case (i_addr)
      `DCMS_ADDR_MODE_CLK: rdata_d = r_mode_clk_q;
      `DCMS_ADDR_FILT_DEM: rdata_d = r_filt_dem_q;
      `DCMS_ADDR_MONO_DSD: rdata_d = r_mono_dsd_q;
      `DCMS_ADDR_ATT_L: rdata_d = r_att_l_q;
      `DCMS_ADDR_ATT_R: rdata_d = r_att_r_q;
      `DCMS_ADDR_FILT_POL: rdata_d = r_filt_pol_q;
      `DCMS_ADDR_DSD_MUTE: rdata_d = r_dsd_mute_q;
      `DCMS_ADDR_GAIN_SYNC: rdata_d = r_gain_sync_q;
      `DCMS_ADDR_SOUND_Q: rdata_d = r_sound_q_q;
      `DCMS_ADDR_DSD_FILT: rdata_d = r_dsd_filt_q;
      `DCMS_ADDR_MULTICH: rdata_d = r_multich_q;
      `DCMS_ADDR_DAISY: rdata_d = r_daisy_q;
      `DCMS_ADDR_AUTO_SW: rdata_d = {r_auto_sw_q[7:2], o_switching, o_mode == `DCMS_MODE_DSD};
      default: rdata_d = 8'h00;
    endcase
  end

  // ****************************************************************
  // Conversion mode
  // ****************************************************************
  dcms_mode_decode u_decode (
    .i_pin_ctrl(pin_ctrl),
    .i_auto_en(r_auto_sw_q[`DCMS_B15_AUTO_EN]),
    .i_dsd_bit(r_mono_dsd_q[`DCMS_B2_DSD_MODE]),
    .i_ext_filter_mode_bit_bit(r_mode_clk_q[`DCMS_B0_EXT_FILTER]),
    .i_dsd_detected(i_dsd_detected),
    .o_mode(mode_d)
  );

  // A mode change is expected only with soft reset held; the timer still
  // runs on any change so the datapath sees a defined switchover window.
  dcms_switch_timer u_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(mode_d != mode_prev_q),
    .i_fsb_tick(i_fsb_tick),
    .o_busy(busy)
  );

  // ****************************************************************
  // Effective settings
  // ****************************************************************
  wire is_dsd = (mode_d == `DCMS_MODE_DSD);
  wire dsd_bypass = is_dsd && r_dsd_mute_q[`DCMS_B6_ROUTE];
  wire zero_pol = r_mono_dsd_q[`DCMS_B2_ZERO_POL];
  wire port_a = r_dsd_mute_q[`DCMS_B6_PORT_SEL];

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      mode_prev_q <= `DCMS_MODE_PCM;
      o_rdata <= 8'h00;
      o_pin_ctrl <= 1'b0;
      o_mode <= `DCMS_MODE_PCM;
      o_switching <= 1'b0;
      o_core_reset <= 1'b1;
      o_bit_clock <= 1'b0;
      o_frame_clock <= 1'b0;
      o_left_data <= 1'b0;
      o_right_data <= 1'b0;
      o_clk_auto <= 1'b0;
      o_short_delay <= 1'b0;
      o_super_slow <= 1'b0;
      o_deemph <= DEEMPH_OFF;
      o_atten_l <= `DCMS_ATT_0DB;
      o_atten_r <= `DCMS_ATT_0DB;
      o_mono <= 1'b0;
      o_ch_select <= 1'b0;
      o_invert_l <= 1'b0;
      o_invert_r <= 1'b0;
      o_sound_quality <= `DCMS_SQ_PIN;
      o_soft_mute <= 1'b0;
      o_mclk_standby_en <= 1'b1;
      o_clock_sync_en <= 1'b1;
      o_dsd_fs_mute <= 1'b0;
      o_zero_flag_l <= 1'b0;
      o_zero_flag_r <= 1'b0;
    end else begin
      mode_prev_q <= mode_d;
      o_rdata <= i_rd_en ? rdata_d : 8'h00;
      o_pin_ctrl <= pin_ctrl;
      o_mode <= mode_d;
      o_switching <= busy;
      // Input routing by conversion mode.
      case (mode_d)
        `DCMS_MODE_DSD: begin
          o_bit_clock <= port_a ? i_dsd_port_a_clock : i_dsd_port_b_clock;
          o_frame_clock <= 1'b0;
          o_left_data <= port_a ? i_dsd_port_a_left : i_dsd_port_b_left;
          o_right_data <= port_a ? i_dsd_port_a_right : i_dsd_port_b_right;
        end
        `DCMS_MODE_EXT_FILTER_MODE_BIT: begin
          o_bit_clock <= i_ext_filter_bit_clock;
          o_frame_clock <= i_ext_filter_word_clock;
          o_left_data <= i_ext_filter_left_data;
          o_right_data <= i_ext_filter_right_data;
        end
        default: begin
          o_bit_clock <= i_pcm_bit_clock;
          o_frame_clock <= i_pcm_frame_clock;
          o_left_data <= i_pcm_serial_data;
          o_right_data <= i_pcm_serial_data;
        end
      endcase
      if (pin_ctrl) begin
        o_core_reset <= 1'b0;
        o_clk_auto <= i_pin_clk_auto;
        o_short_delay <= i_pin_short_delay;
        o_super_slow <= i_pin_super_slow | i_high_speed;
        o_deemph <= i_pin_deemph_on ? DEEMPH_44K1 : DEEMPH_OFF;
        o_atten_l <= `DCMS_ATT_0DB;
        o_atten_r <= `DCMS_ATT_0DB;
        o_mono <= 1'b0;
        o_ch_select <= 1'b0;
        o_invert_l <= 1'b0;
        o_invert_r <= i_pin_invert_r;
        o_sound_quality <= `DCMS_SQ_PIN;
        o_soft_mute <= i_pin_soft_mute;
        o_mclk_standby_en <= 1'b1;
        o_clock_sync_en <= 1'b1;
        o_dsd_fs_mute <= 1'b0;
        o_zero_flag_l <= 1'b0;
        o_zero_flag_r <= 1'b0;
      end else begin
        o_core_reset <= ~r_mode_clk_q[`DCMS_B0_SOFT_RESET];
        o_clk_auto <= (mode_d == `DCMS_MODE_PCM) &&
                      r_mode_clk_q[`DCMS_B0_CLK_AUTO];
        o_short_delay <= r_filt_dem_q[`DCMS_B1_SHORT_DELAY];
        o_super_slow <= r_filt_pol_q[`DCMS_B5_SUPER_SLOW] | i_high_speed;
        o_deemph <= r_filt_dem_q[2:1];
        o_atten_l <= dsd_bypass ? `DCMS_ATT_0DB : r_att_l_q;
        o_atten_r <= dsd_bypass ? `DCMS_ATT_0DB : r_att_r_q;
        o_mono <= r_mono_dsd_q[`DCMS_B2_MONO];
        o_ch_select <= r_mono_dsd_q[`DCMS_B2_CH_SELECT];
        o_invert_l <= r_filt_pol_q[`DCMS_B5_INV_L];
        o_invert_r <= r_filt_pol_q[`DCMS_B5_INV_R];
        o_sound_quality <= r_sound_q_q[2:0];
        o_soft_mute <= r_filt_dem_q[`DCMS_B1_SOFT_MUTE] && !dsd_bypass;
        o_mclk_standby_en <= 1'b1;
        o_clock_sync_en <= r_gain_sync_q[`DCMS_B7_SYNC_EN] && !is_dsd;
        o_dsd_fs_mute <= is_dsd && r_dsd_mute_q[`DCMS_B6_FS_MUTE];
        // Zero flags: enabled only off the bypass path, then polarity.
        o_zero_flag_l <= ((r_filt_dem_q[`DCMS_B1_ZERO_DET_EN] && !dsd_bypass
                          && i_zero_l) ^ zero_pol);
        o_zero_flag_r <= ((r_filt_dem_q[`DCMS_B1_ZERO_DET_EN] && !dsd_bypass
                          && i_zero_r) ^ zero_pol);
      end
    end
  end

endmodule // dcms_ctrl

/* File: bench/dcms_ctrl_checker.sv */
/* Port checker for dcms_ctrl, bound into every instance.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module dcms_ctrl_checker #(
  parameter ADDR_W = 5
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_rd_en,
  input wire i_fsb_tick,
  input wire i_pcm_bit_clock,
  input wire i_pcm_frame_clock,
  input wire i_pcm_serial_data,
  input wire [7:0] o_rdata,
  input wire o_pin_ctrl,
  input wire [1:0] o_mode,
  input wire o_switching,
  input wire o_core_reset,
  input wire o_bit_clock,
  input wire o_frame_clock,
  input wire o_left_data,
  input wire o_right_data,
  input wire [7:0] o_atten_l,
  input wire [7:0] o_atten_r,
  input wire o_mono,
  input wire o_ch_select,
  input wire o_invert_l,
  input wire [2:0] o_sound_quality,
  input wire o_mclk_standby_en,
  input wire o_clock_sync_en,
  input wire o_zero_flag_l,
  input wire o_zero_flag_r
);
  reg [1:0] pin_cnt_q;
  reg [2:0] tick_q;
  reg [1:0] mode_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Pin control counts as settled after three cycles; ticks are counted
  // from the latest mode change while the switchover window is open.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_cnt_q <= 2'h0;
      tick_q <= 3'h0;
      mode_q <= 2'h0;
    end else begin
      pin_cnt_q <= !o_pin_ctrl ? 2'h0 :
        (pin_cnt_q == 2'h3 ? 2'h3 : pin_cnt_q + 2'h1);
      mode_q <= o_mode;
      tick_q <= (!o_switching || o_mode != mode_q) ? 3'h0 :
        tick_q + {2'h0, i_fsb_tick};
    end
  end
  a_pin_pcm_only: assert property (pin_cnt_q == 2'h3 |-> o_mode == 2'h0)
    else $error("mode not PCM under pin control");
  a_pin_atten_fixed: assert property (pin_cnt_q == 2'h3 |->
    o_atten_l == 8'hff && o_atten_r == 8'hff && !o_zero_flag_l &&
    !o_zero_flag_r) else $error("attenuation or zero flag not fixed");
  a_pin_stereo_only: assert property (pin_cnt_q == 2'h3 |->
    !o_mono && !o_ch_select && !o_invert_l && o_sound_quality == 3'h0)
    else $error("pin control output selection wrong");
  a_pin_always_on: assert property (pin_cnt_q == 2'h3 |->
    o_mclk_standby_en && o_clock_sync_en && !o_core_reset)
    else $error("pin control standby, sync or reset wrong");
  a_pin_pcm_route: assert property (pin_cnt_q == 2'h3 |->
    o_bit_clock == $past(i_pcm_bit_clock) &&
    o_frame_clock == $past(i_pcm_frame_clock) &&
    o_left_data == $past(i_pcm_serial_data) &&
    o_right_data == $past(i_pcm_serial_data))
    else $error("PCM inputs not routed");
  a_rdata_idle_zero: assert property (!$past(i_rd_en) |-> o_rdata == 8'h00)
    else $error("read data not zero without read");
  a_switch_start: assert property (o_mode != mode_q |-> ##[0:1] o_switching)
    else $error("switchover window not opened");
  a_switch_min_ticks: assert property ($fell(o_switching) |->
    tick_q >= 3'h2 && tick_q <= 3'h3)
    else $error("switchover closed outside two to three samples");
  a_switch_max_ticks: assert property (o_switching |-> tick_q <= 3'h3)
    else $error("switchover longer than three samples");
endmodule // dcms_ctrl_checker

bind dcms_ctrl dcms_ctrl_checker #(.ADDR_W(ADDR_W)) u_checker (
  .i_clk, .i_resetn, .i_rd_en, .i_fsb_tick, .i_pcm_bit_clock,
  .i_pcm_frame_clock, .i_pcm_serial_data, .o_rdata, .o_pin_ctrl, .o_mode,
  .o_switching, .o_core_reset, .o_bit_clock, .o_frame_clock, .o_left_data,
  .o_right_data, .o_atten_l, .o_atten_r, .o_mono, .o_ch_select,
  .o_invert_l, .o_sound_quality, .o_mclk_standby_en, .o_clock_sync_en,
  .o_zero_flag_l, .o_zero_flag_r
);

/* File: bench/dcms_host.sv */
/* Host controller model: power-down, control-mode pin, register port.
   Assumes the testbench calls its tasks and owns the clock. */
`timescale 1ns/1ps
module dcms_host (
  input wire i_clk,
  input wire [7:0] i_rdata,
  output reg o_resetn,
  output reg o_sel,
  output reg o_wr,
  output reg o_rd,
  output reg [4:0] o_addr,
  output reg [7:0] o_wdata
);
  initial begin
    o_resetn = 1'b0;
    o_sel = 1'b0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 5'h00;
    o_wdata = 8'h00;
  end
  // The select pin only moves while power-down is held.
  task automatic pwr_cycle(input logic sel);
    @(negedge i_clk);
    o_resetn = 1'b0;
    o_sel = sel;
    repeat (6) @(negedge i_clk);
    o_resetn = 1'b1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule // dcms_host

/* File: bench/tb.sv */
/* Self-checking testbench for dcms_ctrl with a host model.
   Assumes the checker is bound in and inputs change on falling edges. */
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  wire i_resetn, i_control_mode_select_pin, i_wr_en, i_rd_en;
  wire [4:0] i_addr;
  wire [7:0] i_wdata;
  logic [7:0] o_rdata, o_atten_l, o_atten_r, d, w;
  logic i_pin_clk_auto = 0, i_pin_short_delay = 0, i_pin_soft_mute = 0;
  logic i_pin_super_slow = 0, i_pin_deemph_on = 0, i_pin_invert_r = 0;
  logic i_high_speed = 0, i_dsd_detected = 0, i_fsb_tick = 0;
  logic i_zero_l = 0, i_zero_r = 0, o_short_delay;
  logic [12:0] aud = 13'h0000;
  logic o_pin_ctrl, o_switching, o_core_reset, o_bit_clock, o_frame_clock;
  logic o_left_data, o_right_data, o_clk_auto, o_super_slow, o_mono;
  logic o_ch_select, o_invert_l, o_invert_r, o_mclk_standby_en, o_soft_mute;
  logic o_clock_sync_en, o_dsd_fs_mute, o_zero_flag_l, o_zero_flag_r;
  logic [1:0] o_mode, o_deemph, em, exp_m = 2'h0;
  logic [2:0] o_sound_quality;
  logic [3:0] tcnt = 4'h0, e;
  logic rt_on = 1'b0, port = 1'b0, a, dv, x;
  int miscompares = 0, compares = 0, n;
  int regs[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 21};
  dcms_ctrl i_dut (
    .i_clk, .i_resetn, .i_control_mode_select_pin, .i_wr_en, .i_rd_en,
    .i_addr, .i_wdata, .o_rdata, .i_pin_clk_auto, .i_pin_short_delay,
    .i_pin_super_slow, .i_pin_deemph_on, .i_pin_invert_r, .i_pin_soft_mute,
    .i_high_speed, .i_dsd_detected, .i_fsb_tick, .i_zero_l, .i_zero_r,
    .i_pcm_bit_clock(aud[0]), .i_pcm_frame_clock(aud[1]),
    .i_pcm_serial_data(aud[2]), .i_ext_filter_bit_clock(aud[3]),
    .i_ext_filter_left_data(aud[4]), .i_ext_filter_right_data(aud[5]),
    .i_ext_filter_word_clock(aud[6]), .i_dsd_port_a_clock(aud[7]),
    .i_dsd_port_a_left(aud[8]), .i_dsd_port_a_right(aud[9]),
    .i_dsd_port_b_clock(aud[10]), .i_dsd_port_b_left(aud[11]),
    .i_dsd_port_b_right(aud[12]), .o_pin_ctrl, .o_mode, .o_switching,
    .o_core_reset, .o_bit_clock, .o_frame_clock, .o_left_data,
    .o_right_data, .o_clk_auto, .o_short_delay, .o_super_slow, .o_deemph,
    .o_atten_l, .o_atten_r, .o_mono, .o_ch_select, .o_invert_l, .o_invert_r,
    .o_sound_quality, .o_soft_mute, .o_mclk_standby_en, .o_clock_sync_en,
    .o_dsd_fs_mute, .o_zero_flag_l, .o_zero_flag_r
  );
  dcms_host i_host (.i_clk, .i_rdata(o_rdata), .o_resetn(i_resetn),
    .o_sel(i_control_mode_select_pin), .o_wr(i_wr_en), .o_rd(i_rd_en),
    .o_addr(i_addr), .o_wdata(i_wdata));
  always #5 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] got);
    compares++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] rstv(input int r);
    return (r == 3 || r == 4) ? 8'hff : (r == 7 ? 8'h01 : 8'h00);
  endfunction
  task automatic settle(input int c);
    repeat (c) @(negedge i_clk);
  endtask
  // Sample-rate ticks every 16 cycles, random audio and don't-care pins.
  always @(negedge i_clk) begin
    tcnt <= tcnt + 4'h1;
    i_fsb_tick <= (tcnt == 4'hf);
    if (rt_on) begin
      case (exp_m)
        2'h0: e = {aud[0], aud[1], aud[2], aud[2]};
        2'h1: e = {aud[3], aud[6], aud[4], aud[5]};
        default: e = port ? {aud[7], 1'b0, aud[8], aud[9]} :
          {aud[10], 1'b0, aud[11], aud[12]};
      endcase
      chk("route", {4'h0, e}, {4'h0, o_bit_clock, o_frame_clock,
        o_left_data, o_right_data});
    end
    aud <= 13'($urandom);
    {i_pin_clk_auto, i_pin_short_delay, i_pin_soft_mute} <= 3'($urandom);
  end
  initial begin
    #500000;
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(99));
    i_host.pwr_cycle(1'b0);
    chk("mode", 8'h00, {6'h0, o_mode});
    chk("pin_ctrl", 8'h00, {7'h0, o_pin_ctrl});
    chk("clk_auto", 8'h00, {7'h0, o_clk_auto});
    chk("atten", 8'hff, o_atten_l);
    foreach (regs[i]) begin
      i_host.rd(5'(regs[i]), d);
      chk("reset value", rstv(regs[i]), d);
    end
    i_host.wr(5'h1f, 8'h5a);
    i_host.rd(5'h1f, d);
    chk("unmapped", 8'h00, d);
    $display("test reset values done");
    foreach (regs[i]) if (regs[i] != 0 && regs[i] != 2 && regs[i] < 12) begin
      w = 8'($urandom);
      i_host.wr(5'(regs[i]), w);
      i_host.rd(5'(regs[i]), d);
      chk("readback", w, d);
      if (regs[i] == 3)
        chk("atten_l", w, o_atten_l);
      i_host.wr(5'(regs[i]), rstv(regs[i]));
    end
    $display("test register access done");
    i_host.wr(5'h06, 8'h01);
    for (int i = 0; i < 8; i++) begin
      a = i[2];
      dv = i[2] ? ~i[1] : i[1];
      x = i[0];
      em = ((a ? i[1] : dv) == 1'b1) ? 2'h2 : {1'b0, x};
      i_host.wr(5'h00, 8'h00);
      i_host.wr(5'h00, {6'h0, x, 1'b0});
      i_host.wr(5'h02, {dv, 7'h0});
      i_host.wr(5'h15, {a, 7'h0});
      i_dsd_detected = i[2] ? i[1] : ~i[1];
      settle(3);
      for (n = 0; n < 200 && o_switching !== 1'b0; n++) settle(1);
      chk("switch done", 8'h00, {7'h0, o_switching});
      chk("mode", {6'h0, em}, {6'h0, o_mode});
      settle(64);
      i_host.wr(5'h00, {6'h0, x, 1'b1});
      chk("fs mute", {7'h0, em == 2'h2}, {7'h0, o_dsd_fs_mute});
      exp_m <= em;
      port <= 1'b0;
      rt_on <= 1'b1;
      settle(8);
      rt_on <= 1'b0;
      if (em == 2'h2) begin
        i_host.wr(5'h06, 8'h05);
        port <= 1'b1;
        rt_on <= 1'b1;
        settle(8);
        rt_on <= 1'b0;
        i_host.wr(5'h06, 8'h01);
      end
    end
    i_host.wr(5'h00, 8'h00);
    i_host.wr(5'h15, 8'h00);
    settle(64);
    i_host.wr(5'h00, 8'h01);
    $display("test conversion modes done");
    w = 8'($urandom);
    i_host.wr(5'h04, w);
    i_host.wr(5'h01, 8'h80);
    i_zero_l = 1'b1;
    settle(3);
    chk("atten_r", w, o_atten_r);
    chk("zero flags", 8'h02, {6'h0, o_zero_flag_l, o_zero_flag_r});
    i_host.wr(5'h02, 8'h10);
    settle(2);
    chk("zero flags", 8'h01, {6'h0, o_zero_flag_l, o_zero_flag_r});
    $display("test attenuation and zero flags done");
    i_host.pwr_cycle(1'b1);
    i_pin_invert_r = 1'b1;
    i_pin_deemph_on = 1'b1;
    i_high_speed = 1'b1;
    i_host.wr(5'h02, 8'h80);
    settle(3);
    chk("pin_ctrl", 8'h01, {7'h0, o_pin_ctrl});
    chk("mode", 8'h00, {6'h0, o_mode});
    chk("atten", 8'hff, o_atten_r);
    chk("zero", 8'h00, {6'h0, o_zero_flag_l, o_zero_flag_r});
    chk("deemph", 8'h00, {6'h0, o_deemph});
    chk("super slow", 8'h01, {7'h0, o_super_slow});
    chk("invert", 8'h01, {6'h0, o_invert_l, o_invert_r});
    chk("sound", 8'h00, {5'h0, o_sound_quality});
    chk("mono", 8'h00, {6'h0, o_mono, o_ch_select});
    chk("always on", 8'h06, {5'h0, o_mclk_standby_en, o_clock_sync_en,
      o_core_reset});
    chk("pin fn", {5'h0, i_pin_clk_auto, i_pin_short_delay, i_pin_soft_mute},
      {5'h0, o_clk_auto, o_short_delay, o_soft_mute});
    exp_m <= 2'h0;
    rt_on <= 1'b1;
    settle(8);
    rt_on <= 1'b0;
    i_pin_deemph_on = 1'b0;
    settle(2);
    chk("deemph", 8'h01, {6'h0, o_deemph});
    i_host.rd(5'h02, d);
    chk("refused write", 8'h00, d);
    i_host.pwr_cycle(1'b0);
    settle(2);
    chk("pin ignored", 8'h00, {7'h0, o_invert_r});
    $display("test pin control done");
    finish_test();
  end
endmodule // tb
